// >>> verilog/adc_ctrl_regs.svh
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// ==========================================================================
// Register byte offsets
`define OFF_CTRL        8'h00
`define OFF_RESULT      8'h04
`define OFF_DIV         8'h08
`define OFF_STAT        8'h0c
`define OFF_MASK        8'h10

// ==========================================================================
// Field positions
`define CTRL_CHAN_LSB   0
`define CTRL_CHAN_MSB   2
`define CTRL_CONT_BIT   3
`define CTRL_EN_BIT     4
`define CTRL_START_BIT  7
`define DIV_SEL_LSB     5
`define DIV_SEL_MSB     7
`define STAT_DONE_BIT   0
`define STAT_BUSY_BIT   1
`define MASK_DONE_BIT   0

// ==========================================================================
// Reset values
`define RST_CTRL        8'h00
`define RST_DIV         8'h00
`define RST_MASK        8'h00
`define RST_RESULT      8'h00

// ==========================================================================
// Converter clock divider terminal counts (ratio minus one)
`define DIV_LIM_1       4'h0
`define DIV_LIM_2       4'h1
`define DIV_LIM_4       4'h3
`define DIV_LIM_8       4'h7
`define DIV_LIM_16      4'hf

// ==========================================================================
// Converter geometry
`define NUM_CHANNELS    7
`define RESULT_BITS     8
`define SAR_MSB_IDX     3'h7
`define SAR_START_CODE  8'h80

`endif

// >>> verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ========================================================================
  // Conversion sequencer states, Gray coded along idle-sample-convert-store
  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b11,
    ST_STORE  = 2'b10
  } conv_state_e;

  typedef logic [7:0] sample_t;
  typedef logic [2:0] div_sel_t;
  typedef logic [2:0] bit_idx_t;

endpackage : adc_ctrl_pkg

// >>> verilog/conv_clk_if.sv
`timescale 1ns/1ps

interface conv_clk_if;
  import adc_ctrl_pkg::*;

  div_sel_t div_sel;
  logic     run;
  logic     tick;

  modport ctrl (output div_sel, output run, input tick);
  modport div  (input div_sel, input run, output tick);
endinterface : conv_clk_if

// >>> verilog/conv_clk_div.sv
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module conv_clk_div
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Divider control and tick
  conv_clk_if.div  cif
);

  logic [3:0] cnt_q;
  logic [3:0] limit;
  logic       tick_q;

  // ========================================================================
  // Ratio decode
  always_comb
  begin
    case (cif.div_sel)
      3'h0:    limit = `DIV_LIM_1;  // see RQ8
      3'h1:    limit = `DIV_LIM_2;  // see RQ8
      3'h2:    limit = `DIV_LIM_4;  // see RQ8
      3'h3:    limit = `DIV_LIM_8;  // see RQ8
      default: limit = `DIV_LIM_16; // see RQ8
    endcase
  end

  // ========================================================================
  // Counter; restarts whenever the converter is idle
  always_ff @(posedge clk)
  begin
    if (sys_rst || !cif.run)
    begin
      cnt_q  <= 4'h0;
      tick_q <= 1'b0;
    end
    else if (cnt_q >= limit)
    begin
      cnt_q  <= 4'h0;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 4'h1;
      tick_q <= 1'b0;
    end
  end

  assign cif.tick = tick_q;

  // ========================================================================
  // Checks
  chk_div_by_one: assert property ( // see RQ8
    @(posedge clk) disable iff (sys_rst || !cif.run || cif.div_sel != 3'h0)
    tick_q |=> tick_q)
    else $error("divide by one did not tick every cycle");

  chk_div_by_eight: assert property ( // see RQ8
    @(posedge clk) disable iff (sys_rst || !cif.run || cif.div_sel != 3'h3)
    tick_q |=> !tick_q [*7] ##1 tick_q)
    else $error("divide by eight tick spacing wrong");

endmodule : conv_clk_div

// >>> verilog/sar_adc_control.sv
// Summary of operation
// (RQ1) One of seven channels at a time is routed to the single converter.
// (RQ2) Each result is eight bits, held in one readable result register.
// (RQ3) Single conversion per start, or continuous back-to-back conversions.
// (RQ4) Successive approximation resolves one bit per converter clock step.
// (RQ5) On completion result is stored, then flag set or interrupt raised.
// (RQ6) An unimplemented channel code gives an undefined result.
// (RQ7) Selected channel's port pin is taken over as the converter input.
// (RQ8) Prescaler code divides by 1, 2, 4, 8, or 16 when top bit set.
// (RQ9) Software picks a ratio giving roughly a 1 MHz converter clock.
// (RQ10) Software must not choose a converter clock that is too slow.
// (RQ11) Continuous mode restarts right after each store until stopped.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module sar_adc_control
  import adc_ctrl_pkg::*;
#(
  parameter int NUM_CH = `NUM_CHANNELS
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output wire logic [31:0]       prdata,
  output wire logic              pready,
  output wire logic              pslverr,
  // Analog front end
  input  wire logic              cmp_in,
  output wire logic [7:0]        dac_code,
  output wire logic [NUM_CH-1:0] ana_sel,
  output wire logic              sample_hold,
  // Interrupt
  output wire logic              irq
);

  // ========================================================================
  // Declarations
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [7:0]        ctrl_q;
  logic [7:0]        div_q;
  logic [7:0]        mask_q;
  logic              done_q;
  sample_t           result_q;
  sample_t           sar_q;
  bit_idx_t          bit_q;
  conv_state_e       state_q;
  logic [NUM_CH-1:0] ana_sel_q;
  logic              sample_q;
  logic              irq_q;

  logic              setup_acc;
  logic              done_acc;
  logic              hit;
  logic              wr_ctrl;
  logic              wr_div;
  logic              wr_stat;
  logic              wr_mask;
  logic              start_req;
  logic              conv_en;
  logic              cont_mode;
  logic [2:0]        chan;
  logic              store_evt;
  logic [31:0]       rd_mux;

  conv_clk_if cif ();

  // ========================================================================
  // APB decode: one wait state so read data comes from a flop
  assign setup_acc = psel && penable && !pready_q;
  assign done_acc  = psel && penable && pready_q;

  always_comb
  begin
    hit = 1'b1;
    case (paddr)
      `OFF_CTRL:   rd_mux = {24'h000000, 1'b0, ctrl_q[6:0]};
      `OFF_RESULT: rd_mux = {24'h000000, result_q}; // see RQ2
      `OFF_DIV:    rd_mux = {24'h000000, div_q[7:5], 5'h00};
      `OFF_STAT:   rd_mux = {30'h00000000, (state_q != ST_IDLE), done_q};
      `OFF_MASK:   rd_mux = {24'h000000, 7'h00, mask_q[`MASK_DONE_BIT]};
      default:
      begin
        rd_mux = 32'h00000000;
        hit    = 1'b0;
      end
    endcase
  end

  assign wr_ctrl = done_acc && pwrite && (paddr == `OFF_CTRL);
  assign wr_div  = done_acc && pwrite && (paddr == `OFF_DIV);
  assign wr_stat = done_acc && pwrite && (paddr == `OFF_STAT);
  assign wr_mask = done_acc && pwrite && (paddr == `OFF_MASK);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      pready_q  <= setup_acc;
      pslverr_q <= setup_acc && !hit;
      if (setup_acc && !pwrite)
      begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ========================================================================
  // Control, divider and mask registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= `RST_CTRL;
    end
    else if (wr_ctrl)
    begin
      ctrl_q <= {1'b0, pwdata[6:0]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_q <= `RST_DIV;
    end
    else if (wr_div)
    begin
      div_q <= {pwdata[`DIV_SEL_MSB:`DIV_SEL_LSB], 5'h00}; // see RQ8
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mask_q <= `RST_MASK;
    end
    else if (wr_mask)
    begin
      mask_q <= {7'h00, pwdata[`MASK_DONE_BIT]};
    end
  end

  assign chan      = ctrl_q[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB];
  assign cont_mode = ctrl_q[`CTRL_CONT_BIT];
  assign conv_en   = ctrl_q[`CTRL_EN_BIT];
  assign start_req = wr_ctrl && pwdata[`CTRL_START_BIT] && pwdata[`CTRL_EN_BIT];
  assign store_evt = (state_q == ST_STORE);

  // ========================================================================
  // Converter clock prescaler
  assign cif.div_sel = div_q[`DIV_SEL_MSB:`DIV_SEL_LSB];
  assign cif.run     = (state_q != ST_IDLE);

  conv_clk_div u_div
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cif     (cif.div)
  );

  // ========================================================================
  // Conversion sequencer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
    end
    else if (!conv_en && !start_req)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start_req)
          begin
            state_q <= ST_SAMPLE; // see RQ3
          end
        end
        ST_SAMPLE:
        begin
          if (cif.tick)
          begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (cif.tick && bit_q == 3'h0)
          begin
            state_q <= ST_STORE;
          end
        end
        ST_STORE:
        begin
          state_q <= cont_mode ? ST_SAMPLE : ST_IDLE; // see RQ3, see RQ11
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Successive approximation register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sar_q <= 8'h00;
      bit_q <= 3'h0;
    end
    else if (state_q == ST_SAMPLE && cif.tick)
    begin
      sar_q <= `SAR_START_CODE; // see RQ4
      bit_q <= `SAR_MSB_IDX;
    end
    else if (state_q == ST_CONV && cif.tick)
    begin
      if (!cmp_in)
      begin
        sar_q[bit_q] <= 1'b0; // see RQ4
      end
      if (bit_q != 3'h0)
      begin
        sar_q[bit_q - 3'h1] <= 1'b1; // see RQ4
        bit_q               <= bit_q - 3'h1;
      end
    end
  end

  // ========================================================================
  // Result store; an unimplemented channel still stores, value undefined
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      result_q <= `RST_RESULT;
    end
    else if (store_evt)
    begin
      result_q <= sar_q; // see RQ2, see RQ5, see RQ6
    end
  end

  // ========================================================================
  // Channel mux and pin takeover
  generate
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_chan
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          ana_sel_q[i] <= 1'b0;
        end
        else
        begin
          ana_sel_q[i] <= conv_en && (chan == 3'(i)); // see RQ1, see RQ7
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sample_q <= 1'b0;
    end
    else
    begin
      sample_q <= (state_q == ST_SAMPLE) && conv_en;
    end
  end

  // ========================================================================
  // Completion flag and interrupt; a new completion beats a clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= store_evt || (done_q && !(wr_stat && pwdata[`STAT_DONE_BIT])); // see RQ5
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= done_q && mask_q[`MASK_DONE_BIT]; // see RQ5
    end
  end

  // ========================================================================
  // Outputs
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign dac_code    = sar_q;
  assign ana_sel     = ana_sel_q;
  assign sample_hold = sample_q;
  assign irq         = irq_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_mux_one_hot: assert property ($onehot0(ana_sel_q)) // see RQ1
    else $error("more than one channel routed");

  chk_result_store: assert property ( // see RQ2
    store_evt |=> (result_q == $past(sar_q)) && done_q)
    else $error("result not stored on completion");

  chk_single_stop: assert property ( // see RQ3
    store_evt && !cont_mode && conv_en && !wr_ctrl |=> state_q == ST_IDLE)
    else $error("single mode did not stop");

  chk_cont_restart: assert property ( // see RQ11
    store_evt && cont_mode && conv_en && !wr_ctrl |=> state_q == ST_SAMPLE)
    else $error("continuous mode did not restart");

  chk_bit_step: assert property ( // see RQ4
    state_q == ST_CONV && cif.tick && bit_q != 3'h0 && conv_en
    |=> bit_q == $past(bit_q) - 3'h1 && sar_q[bit_q])
    else $error("approximation step wrong");

  chk_flag_set_wins: assert property ( // see RQ5
    store_evt && wr_stat && pwdata[`STAT_DONE_BIT] |=> done_q)
    else $error("completion lost to clear");

  chk_irq_gating: assert property ( // see RQ5
    done_q && mask_q[`MASK_DONE_BIT] ##1 done_q |-> irq_q)
    else $error("interrupt not raised");

  chk_irq_masked: assert property ( // see RQ5
    !mask_q[`MASK_DONE_BIT] ##1 !mask_q[`MASK_DONE_BIT] |-> !irq_q)
    else $error("masked interrupt raised");

  chk_pin_follows: assert property ( // see RQ7
    conv_en && chan < 3'h7 && !wr_ctrl |=> ana_sel_q[chan])
    else $error("selected pin not taken over");

  cov_single_done: cover property (
    start_req && !pwdata[`CTRL_CONT_BIT] ##[1:300] store_evt);

  cov_cont_two: cover property (
    store_evt && cont_mode ##[1:300] store_evt);

  cov_irq_high: cover property ($rose(irq_q));

endmodule : sar_adc_control

// >>> dv/analog_src_model.sv
`timescale 1ns/1ps

module analog_src_model
  import adc_ctrl_pkg::*;
#(
  parameter int NUM_CH = 7
)
(
  // Clock
  input  wire logic                   clk,
  // Converter side
  input  wire logic [NUM_CH-1:0]      ana_sel,
  input  wire logic                   sample_hold,
  input  wire logic [7:0]             dac_code,
  output logic                        cmp_in,
  // Source levels as ideal codes
  input  wire logic [NUM_CH-1:0][7:0] vin
);
  sample_t held_q = 8'h00;
  logic    tog_q  = 1'b0;
  logic    hit;
  sample_t pin_v;

  // ==========================================================================
  // Port pin of the selected channel
  always_comb
  begin
    hit   = 1'b0;
    pin_v = 8'h00;
    for (int i = 0; i < NUM_CH; i++)
      if (ana_sel[i])
      begin
        hit   = 1'b1;
        pin_v = vin[i];
      end
  end

  // ==========================================================================
  // Hold capacitor tracks while sampling; unselected input wanders
  always_ff @(posedge clk)
  begin
    tog_q <= ~tog_q;
    if (sample_hold)
      held_q <= pin_v;
  end

  assign cmp_in = hit ? (held_q >= dac_code) : tog_q;
endmodule : analog_src_model

// >>> dv/sar_adc_control_tb.sv
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, e, s); end end

module sar_adc_control_tb;
  import adc_ctrl_pkg::*;

  logic              clk     = 1'b0;
  logic              sys_rst = 1'b1;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [7:0]        paddr   = 8'h00;
  logic [31:0]       pwdata  = 32'h0;
  logic [6:0][7:0]   vin     = '0;
  logic [31:0]       prdata, rd;
  logic              pready, pslverr, cmp_in, sample_hold, irq;
  logic [7:0]        dac_code;
  logic [6:0]        ana_sel;
  int                error_cnt = 0;
  int                n_tests   = 0;
  logic [7:0]        lvl [7] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h01, 8'haa, 8'h55};

  always #50 clk = ~clk;

  sar_adc_control u_sar_adc_control (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in), .dac_code(dac_code),
    .ana_sel(ana_sel), .sample_hold(sample_hold), .irq(irq));

  analog_src_model u_analog_src_model (.clk(clk), .ana_sel(ana_sel),
    .sample_hold(sample_hold), .dac_code(dac_code), .cmp_in(cmp_in), .vin(vin));

  // ==========================================================================
  // Closing and bus helpers
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic fail_wait;
    error_cnt++;
    $display("ERROR wait expected answer seen timeout");
    report_and_stop();
  endtask : fail_wait

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic err = 1'b0);
    int i;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
      fail_wait();
    rd = prdata;
    `CHK("slave error", err, pslverr)
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("read data", e, rd)
  endtask : rchk

  task automatic wait_done;
    for (int i = 0; i < 100; i++)
    begin
      apb(1'b0, `OFF_STAT, 32'h0);
      if (rd[0] === 1'b1)
        break;
    end
    if (rd[0] !== 1'b1)
      fail_wait();
  endtask : wait_done

  task automatic wait_dac(input logic [7:0] v, input bit eq, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 400)
        fail_wait();
    end while ((dac_code === v) != eq);
  endtask : wait_dac

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    for (int a = 0; a < 5; a++)
      rchk(8'(a * 4), 32'h0);
    `CHK("idle pins", 8'h00, {irq, ana_sel})
    apb(1'b0, 8'h14, 32'h0, 1'b1);
    `CHK("unmapped read", 32'h0, rd)
    apb(1'b1, 8'h14, 32'hff, 1'b1);
    apb(1'b1, `OFF_RESULT, 32'hff);
    rchk(`OFF_RESULT, 32'h0);
    apb(1'b1, `OFF_DIV, 32'hff);
    rchk(`OFF_DIV, 32'he0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_channels;
    int n;
    apb(1'b1, `OFF_DIV, 32'h60);
    for (int ch = 0; ch < 7; ch++)
    begin
      vin[ch] <= lvl[ch];
      apb(1'b1, `OFF_CTRL, 32'h90 | ch);
      wait_dac(8'h80, 1'b1, n);
      `CHK("channel", 7'h1 << ch, ana_sel)
      wait_done();
      rchk(`OFF_RESULT, {24'h0, lvl[ch]});
      apb(1'b1, `OFF_STAT, 32'h1);
    end
    $display("test channels done");
  endtask : t_channels

  task automatic t_prescale;
    int n;
    int code [6] = '{0, 1, 2, 3, 4, 7};
    int ratio [6] = '{1, 2, 4, 8, 16, 16};
    vin[0] <= 8'h55;
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b1, `OFF_DIV, code[k] << 5);
      apb(1'b1, `OFF_CTRL, 32'h90);
      wait_dac(8'h40, 1'b1, n);
      wait_dac(8'h40, 1'b0, n);
      `CHK("step period", ratio[k], n)
      wait_done();
      rchk(`OFF_RESULT, 32'h55);
      apb(1'b1, `OFF_STAT, 32'h1);
    end
    $display("test prescale done");
  endtask : t_prescale

  task automatic t_cont;
    vin[3] <= 8'h3c;
    apb(1'b1, `OFF_DIV, 32'h60);
    apb(1'b1, `OFF_CTRL, 32'h9b);
    wait_done();
    rchk(`OFF_RESULT, 32'h3c);
    apb(1'b1, `OFF_STAT, 32'h1);
    rchk(`OFF_STAT, 32'h2);
    wait_done();
    rchk(`OFF_RESULT, 32'h3c);
    apb(1'b1, `OFF_STAT, 32'h1);
    apb(1'b1, `OFF_CTRL, 32'h0);
    rchk(`OFF_STAT, 32'h0);
    `CHK("stopped channel", 7'h0, ana_sel)
    $display("test continuous done");
  endtask : t_cont

  task automatic t_irq;
    vin[5] <= 8'h99;
    apb(1'b1, `OFF_MASK, 32'h1);
    apb(1'b1, `OFF_CTRL, 32'h95);
    wait_done();
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, `OFF_STAT, 32'h1);
    @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b1, `OFF_MASK, 32'h0);
    apb(1'b1, `OFF_CTRL, 32'h95);
    wait_done();
    `CHK("irq masked", 1'b0, irq)
    rchk(`OFF_RESULT, 32'h99);
    apb(1'b1, `OFF_STAT, 32'h1);
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_chan7;
    apb(1'b1, `OFF_CTRL, 32'h97);
    apb(1'b0, `OFF_STAT, 32'h0);
    `CHK("busy", 1'b1, rd[1])
    `CHK("no pin", 7'h0, ana_sel)
    wait_done();
    apb(1'b1, `OFF_STAT, 32'h1);
    $display("test unused channel done");
  endtask : t_chan7

  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_channels();
    t_prescale();
    t_cont();
    t_irq();
    t_chan7();
    report_and_stop();
  end
endmodule : sar_adc_control_tb
